// [verilog/ram_port_defines.svh]
`ifndef RAM_PORT_DEFINES_SVH
`define RAM_PORT_DEFINES_SVH

// ----------------------------------------------------------------
// register map (byte addresses, one aligned word each)
// ----------------------------------------------------------------
`define REG_CONTROL_OFFSET 8'h00
`define REG_STATUS_OFFSET 8'h04
`define REG_COUNTER_OFFSET 8'h08
`define REG_WRITE_COUNT_OFFSET 8'h0c

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CONTROL_WRITE_PROTECT_BIT 0
`define STATUS_POWERED_DOWN_BIT 0
`define STATUS_DRIVING_BIT 1
`define STATUS_LATENCY_BIT 2
`define STATUS_SELECTED_BIT 3

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define CONTROL_RESET 1'h0
`define COUNTER_RESET 32'h0000_0000

// ----------------------------------------------------------------
// bus answers
// ----------------------------------------------------------------
`define AXI_RESP_OKAY 2'h0
`define AXI_RESP_SLVERR 2'h2

`endif

// [verilog/ram_port_pkg.sv]
package ram_port_pkg;

   // ----------------------------------------------------------------
   // where the access address comes from in a cycle
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      SRC_CLEAR,
      SRC_LOAD,
      SRC_ADVANCE,
      SRC_HOLD
   } addr_src_t;

   typedef logic [1:0] axi_resp_t;

endpackage

// [verilog/addr_seq_if.sv]
`timescale 1ns/1ns
interface addr_seq_if #(
   parameter int ADDR_W = 14
) ();
   logic load_n;
   logic advance_n;
   logic clear_n;
   logic [ADDR_W-1:0] ext_addr;
   logic [ADDR_W-1:0] int_addr;
   logic [ADDR_W-1:0] counter;

   modport owner (
      output load_n,
      output advance_n,
      output clear_n,
      output ext_addr,
      input int_addr,
      input counter
   );

   modport seq (
      input load_n,
      input advance_n,
      input clear_n,
      input ext_addr,
      output int_addr,
      output counter
   );
endinterface

// [verilog/address_sequencer.sv]
`timescale 1ns/1ns
module address_sequencer
   import ram_port_pkg::*;
#(
   parameter int ADDR_W = 14
) (
   input wire logic aclk,
   input wire logic aresetn,
   addr_seq_if.seq bus
);

   addr_src_t src;
   logic [ADDR_W-1:0] counter;
   logic [ADDR_W-1:0] int_addr;
   logic [ADDR_W-1:0] next_counter;

   generate
      if (ADDR_W < 1) begin : g_bad_addr_w
         $error("address width must be at least one bit");
      end
   endgenerate

   // ----------------------------------------------------------------
   // source choice: clear beats load beats advance
   // ----------------------------------------------------------------
   always_comb begin
      if (!bus.clear_n) begin
         src = SRC_CLEAR;
      end else if (!bus.load_n) begin
         src = SRC_LOAD;
      end else if (!bus.advance_n) begin
         src = SRC_ADVANCE;
      end else begin
         src = SRC_HOLD;
      end
   end

   // ----------------------------------------------------------------
   // access address of this cycle and next counter value
   // ----------------------------------------------------------------
   always_comb begin
      case (src)
         SRC_CLEAR: int_addr = '0;
         SRC_LOAD: int_addr = bus.ext_addr;
         // width truncation wraps the top address back to zero
         SRC_ADVANCE: int_addr = ADDR_W'(counter + 1'b1);
         SRC_HOLD: int_addr = counter;
         default: int_addr = counter;
      endcase
      next_counter = int_addr;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         counter <= '0;
      end else begin
         counter <= next_counter;
      end
   end

   assign bus.int_addr = int_addr;
   assign bus.counter = counter;

endmodule

// [verilog/dual_port_sync_ram_port_logic.sv]
// Implementation choices: the AXI4-Lite register port and the address map.
`timescale 1ns/1ns
`include "ram_port_defines.svh"
// Contract
// - inputs captured in registers at the edge
// - all registers change on rising aclk only
// - write completes within its own cycle
// - output enable gates drivers without clock
// - strobe low loads external address each edge
// - access address is external or counter
// - advance increments, access uses incremented address
// - advance high holds the counter
// - no load, no advance: same data repeats
// - counter clear accesses address zero, no dead cycle
// - output state from previous cycle controls
// - deselected one cycle powers port down
// - pipelined needs two selected cycles to drive
// - two chip selects combined internally
// - latency select high pipelined, low flow-through
// - output enable and latency select asynchronous
// - deselect gives high impedance after next edge
module dual_port_sync_ram_port_logic
   import ram_port_pkg::*;
#(
   parameter int DATA_W = 9,
   parameter int ADDR_W = 14
) (
   input wire logic aclk,
   input wire logic aresetn,
   // memory port pins
   input wire logic chip_select_active_low_n,
   input wire logic chip_select_active_high,
   input wire logic address_load_strobe_n,
   input wire logic counter_advance_enable_n,
   input wire logic counter_clear_n,
   input wire logic read_select,
   input wire logic output_enable_n,
   input wire logic output_latency_select,
   input wire logic [ADDR_W-1:0] ext_address,
   input wire logic [DATA_W-1:0] write_data,
   output logic [DATA_W-1:0] read_data,
   output logic read_data_oe_n,
   // axi4-lite slave
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);

   localparam int DEPTH = 1 << ADDR_W;

   // ----------------------------------------------------------------
   // parameter checks
   // ----------------------------------------------------------------
   // counter readback is one 32-bit word, so the address stays narrow
   generate
      if (DATA_W < 1 || DATA_W > 32) begin : g_bad_data_w
         $error("data width must lie between 1 and 32");
      end
      if (ADDR_W < 1 || ADDR_W > 20) begin : g_bad_addr_w
         $error("address width must lie between 1 and 20");
      end
   endgenerate

   // ----------------------------------------------------------------
   // register decode, by word
   // ----------------------------------------------------------------
   function automatic logic word_is(input logic [7:0] addr, input logic [7:0] offset);
      word_is = (addr[7:2] == offset[7:2]);
   endfunction

   // ----------------------------------------------------------------
   // port state
   // ----------------------------------------------------------------
   logic [DATA_W-1:0] mem [DEPTH];
   logic selected;
   logic write_en;
   logic flow_drive;
   logic pipe_drive;
   logic powered_down;
   logic [DATA_W-1:0] flow_data;
   logic [DATA_W-1:0] pipe_data;
   logic [15:0] write_count;
   logic next_flow_drive;
   logic next_pipe_drive;
   logic next_powered_down;
   logic [DATA_W-1:0] next_flow_data;
   logic [DATA_W-1:0] next_pipe_data;
   logic [15:0] next_write_count;

   // ----------------------------------------------------------------
   // register bus state
   // ----------------------------------------------------------------
   logic write_protect;
   logic aw_held;
   logic w_held;
   logic [7:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic awready;
   logic wready;
   logic bvalid;
   axi_resp_t bresp;
   logic arready;
   logic rvalid;
   logic [31:0] rdata;
   axi_resp_t rresp;
   logic next_write_protect;
   logic next_aw_held;
   logic next_w_held;
   logic [7:0] next_aw_addr;
   logic [31:0] next_w_data;
   logic [3:0] next_w_strb;
   logic next_awready;
   logic next_wready;
   logic next_bvalid;
   axi_resp_t next_bresp;
   logic next_arready;
   logic next_rvalid;
   logic [31:0] next_rdata;
   axi_resp_t next_rresp;
   logic [31:0] status_word;

   addr_seq_if #(.ADDR_W(ADDR_W)) seq_bus ();

   assign seq_bus.load_n = address_load_strobe_n;
   assign seq_bus.advance_n = counter_advance_enable_n;
   assign seq_bus.clear_n = counter_clear_n;
   assign seq_bus.ext_addr = ext_address;

   address_sequencer #(.ADDR_W(ADDR_W)) u_seq (
      .aclk(aclk),
      .aresetn(aresetn),
      .bus(seq_bus)
   );

   // ----------------------------------------------------------------
   // access decode and output pipeline
   // ----------------------------------------------------------------
   always_comb begin
      // no external bank decode needed: both selects must agree
      selected = !chip_select_active_low_n && chip_select_active_high;
      write_en = selected && !read_select && !write_protect;
      next_powered_down = !selected;
      next_flow_drive = selected && read_select;
      next_pipe_drive = flow_drive && selected && read_select;
      next_flow_data = flow_data;
      if (selected && read_select) begin
         next_flow_data = mem[seq_bus.int_addr];
      end
      next_pipe_data = flow_data;
      next_write_count = write_count;
      if (write_en) begin
         next_write_count = 16'(write_count + 1'b1);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flow_drive <= 1'b0;
         pipe_drive <= 1'b0;
         powered_down <= 1'b1;
         flow_data <= '0;
         pipe_data <= '0;
         write_count <= '0;
      end else begin
         flow_drive <= next_flow_drive;
         pipe_drive <= next_pipe_drive;
         powered_down <= next_powered_down;
         flow_data <= next_flow_data;
         pipe_data <= next_pipe_data;
         write_count <= next_write_count;
      end
   end

   // ----------------------------------------------------------------
   // array write
   // ----------------------------------------------------------------
   // the whole store lands at the edge, nothing spans cycles
   always_ff @(posedge aclk) begin
      if (write_en) begin
         mem[seq_bus.int_addr] <= write_data;
      end
   end

   // ----------------------------------------------------------------
   // output drivers
   // ----------------------------------------------------------------
   // latency and output enable stay asynchronous, so these are gates on flops
   always_comb begin
      if (output_latency_select) begin
         read_data = pipe_data;
         read_data_oe_n = !(pipe_drive && !output_enable_n);
      end else begin
         read_data = flow_data;
         read_data_oe_n = !(flow_drive && !output_enable_n);
      end
   end

   // ----------------------------------------------------------------
   // axi4-lite write channel
   // ----------------------------------------------------------------
   always_comb begin
      next_aw_held = aw_held;
      next_w_held = w_held;
      next_aw_addr = aw_addr;
      next_w_data = w_data;
      next_w_strb = w_strb;
      next_bvalid = bvalid;
      next_bresp = bresp;
      next_write_protect = write_protect;
      if (s_axi_awvalid && awready) begin
         next_aw_held = 1'b1;
         next_aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && wready) begin
         next_w_held = 1'b1;
         next_w_data = s_axi_wdata;
         next_w_strb = s_axi_wstrb;
      end
      if (bvalid && s_axi_bready) begin
         next_bvalid = 1'b0;
      end
      if (aw_held && w_held && !bvalid) begin
         next_aw_held = 1'b0;
         next_w_held = 1'b0;
         next_bvalid = 1'b1;
         next_bresp = `AXI_RESP_OKAY;
         if (word_is(aw_addr, `REG_CONTROL_OFFSET)) begin
            if (w_strb[0]) begin
               next_write_protect = w_data[`CONTROL_WRITE_PROTECT_BIT];
            end
         end else if (!word_is(aw_addr, `REG_STATUS_OFFSET) &&
                      !word_is(aw_addr, `REG_COUNTER_OFFSET) &&
                      !word_is(aw_addr, `REG_WRITE_COUNT_OFFSET)) begin
            next_bresp = `AXI_RESP_SLVERR;
         end
      end
      next_awready = !next_aw_held;
      next_wready = !next_w_held;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= '0;
         w_data <= '0;
         w_strb <= '0;
         awready <= 1'b0;
         wready <= 1'b0;
         bvalid <= 1'b0;
         bresp <= `AXI_RESP_OKAY;
         write_protect <= `CONTROL_RESET;
      end else begin
         aw_held <= next_aw_held;
         w_held <= next_w_held;
         aw_addr <= next_aw_addr;
         w_data <= next_w_data;
         w_strb <= next_w_strb;
         awready <= next_awready;
         wready <= next_wready;
         bvalid <= next_bvalid;
         bresp <= next_bresp;
         write_protect <= next_write_protect;
      end
   end

   // ----------------------------------------------------------------
   // axi4-lite read channel
   // ----------------------------------------------------------------
   always_comb begin
      status_word = '0;
      status_word[`STATUS_POWERED_DOWN_BIT] = powered_down;
      status_word[`STATUS_DRIVING_BIT] = !read_data_oe_n;
      status_word[`STATUS_LATENCY_BIT] = output_latency_select;
      status_word[`STATUS_SELECTED_BIT] = selected;
      next_rvalid = rvalid;
      next_rdata = rdata;
      next_rresp = rresp;
      if (rvalid && s_axi_rready) begin
         next_rvalid = 1'b0;
      end
      if (s_axi_arvalid && arready) begin
         next_rvalid = 1'b1;
         next_rresp = `AXI_RESP_OKAY;
         next_rdata = '0;
         if (word_is(s_axi_araddr, `REG_CONTROL_OFFSET)) begin
            next_rdata[`CONTROL_WRITE_PROTECT_BIT] = write_protect;
         end else if (word_is(s_axi_araddr, `REG_STATUS_OFFSET)) begin
            next_rdata = status_word;
         end else if (word_is(s_axi_araddr, `REG_COUNTER_OFFSET)) begin
            next_rdata = `COUNTER_RESET | 32'(seq_bus.counter);
         end else if (word_is(s_axi_araddr, `REG_WRITE_COUNT_OFFSET)) begin
            next_rdata = 32'(write_count);
         end else begin
            next_rresp = `AXI_RESP_SLVERR;
         end
      end
      next_arready = !next_rvalid;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b0;
         rvalid <= 1'b0;
         rdata <= '0;
         rresp <= `AXI_RESP_OKAY;
      end else begin
         arready <= next_arready;
         rvalid <= next_rvalid;
         rdata <= next_rdata;
         rresp <= next_rresp;
      end
   end

   assign s_axi_awready = awready;
   assign s_axi_wready = wready;
   assign s_axi_bvalid = bvalid;
   assign s_axi_bresp = bresp;
   assign s_axi_arready = arready;
   assign s_axi_rvalid = rvalid;
   assign s_axi_rdata = rdata;
   assign s_axi_rresp = rresp;

endmodule

// [bench/ram_port_checker.sv]
`timescale 1ns/1ns
module ram_port_checker #(
   parameter int DATA_W = 9
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic chip_select_active_low_n,
   input wire logic chip_select_active_high,
   input wire logic address_load_strobe_n,
   input wire logic counter_advance_enable_n,
   input wire logic counter_clear_n,
   input wire logic read_select,
   input wire logic output_enable_n,
   input wire logic output_latency_select,
   input wire logic [DATA_W-1:0] read_data,
   input wire logic read_data_oe_n,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [31:0] s_axi_rdata
);
   logic sel;
   logic rd;
   logic rd_live;
   logic hold;
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   assign sel = !chip_select_active_low_n && chip_select_active_high;
   assign rd = sel && read_select;
   // reset gate keeps $past from seeing reads made before reset
   assign rd_live = rd && aresetn;
   assign hold = address_load_strobe_n && counter_advance_enable_n && counter_clear_n;
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   // ----------------------------------------------------------------
   // port checks
   // ----------------------------------------------------------------
   a_oe_async: assert property (output_enable_n |-> read_data_oe_n)
      else $error("drivers on while output enable high");
   a_deselect_hiz: assert property (!sel |=> read_data_oe_n)
      else $error("drivers on after deselect");
   a_flow_drive: assert property (rd ##1 (!output_latency_select && !output_enable_n) |-> !read_data_oe_n)
      else $error("flow read not driven");
   a_write_quiet: assert property ((sel && !read_select) ##1 !output_latency_select |-> read_data_oe_n)
      else $error("drivers on after write");
   a_pipe_wait: assert property (!(rd && $past(rd)) ##1 output_latency_select |-> read_data_oe_n)
      else $error("pipelined drive after one read");
   a_pipe_drive: assert property (rd ##1 rd ##1 (output_latency_select && !output_enable_n) |-> !read_data_oe_n)
      else $error("pipelined read not driven");
   a_read_hold: assert property (rd && hold && $past(rd_live) && !output_latency_select
      ##1 !output_latency_select |-> $stable(read_data))
      else $error("held read data changed");
   a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer dropped");
   c_flow: cover property (rd ##1 !read_data_oe_n);
   c_pipe: cover property (rd ##1 rd ##1 (output_latency_select && !read_data_oe_n));
   c_write: cover property (sel && !read_select);
endmodule

bind dual_port_sync_ram_port_logic ram_port_checker #(.DATA_W(DATA_W)) ram_port_checker_inst (
   .aclk, .aresetn, .chip_select_active_low_n, .chip_select_active_high, .address_load_strobe_n,
   .counter_advance_enable_n, .counter_clear_n, .read_select, .output_enable_n, .output_latency_select,
   .read_data, .read_data_oe_n, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata
);

// [bench/host_pins.sv]
`timescale 1ns/1ns
module host_pins (
   input wire logic aclk,
   output logic chip_select_active_low_n,
   output logic chip_select_active_high,
   output logic address_load_strobe_n,
   output logic counter_advance_enable_n,
   output logic counter_clear_n,
   output logic read_select,
   output logic [13:0] ext_address, // shared as-is with parallel ports for wider words
   output logic [8:0] write_data
);
   initial begin
      {chip_select_active_low_n, chip_select_active_high} = 2'h2;
      {address_load_strobe_n, counter_advance_enable_n, counter_clear_n, read_select} = 4'hf;
      ext_address = 14'h0000;
      write_data = 9'h000;
   end
   // ----------------------------------------------------------------
   // one access per edge, entered just after an edge
   // ----------------------------------------------------------------
   task automatic op(input logic [1:0] sel_pair, input logic [2:0] ctl, input logic rd,
                     input logic [13:0] a, input logic [8:0] d);
      {chip_select_active_low_n, chip_select_active_high} <= sel_pair;
      {address_load_strobe_n, counter_advance_enable_n, counter_clear_n} <= ctl;
      read_select <= rd;
      // address flips while load strobe is high, data while reading, so a stale value never looks valid
      ext_address <= ctl[2] ? ~ext_address : a;
      write_data <= rd ? ~write_data : d;
      @(posedge aclk);
      #1;
   endtask
endmodule

// [bench/dual_port_sync_ram_port_logic_test.sv]
`timescale 1ns/1ns
`include "ram_port_defines.svh"
module dual_port_sync_ram_port_logic_test;
   import ram_port_pkg::*;
   localparam logic [2:0] LD = 3'h3, ADV = 3'h5, HOLD = 3'h7, CLR = 3'h2;
   localparam logic [1:0] SEL = 2'h1, OFF = 2'h2;
   logic aclk, aresetn, output_enable_n, output_latency_select, read_data_oe_n;
   logic chip_select_active_low_n, chip_select_active_high, address_load_strobe_n;
   logic counter_advance_enable_n, counter_clear_n, read_select;
   logic [13:0] ext_address;
   logic [8:0] write_data, read_data;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   int miscompares = 0, samples_checked = 0, cycles = 0;

   dual_port_sync_ram_port_logic dual_port_sync_ram_port_logic_inst (
      .aclk, .aresetn, .chip_select_active_low_n, .chip_select_active_high, .address_load_strobe_n,
      .counter_advance_enable_n, .counter_clear_n, .read_select, .output_enable_n, .output_latency_select,
      .ext_address, .write_data, .read_data, .read_data_oe_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
   );
   host_pins host_pins_inst (
      .aclk, .chip_select_active_low_n, .chip_select_active_high, .address_load_strobe_n,
      .counter_advance_enable_n, .counter_clear_n, .read_select, .ext_address, .write_data
   );

   initial begin
      aclk = 1'h0;
      forever #50 aclk = ~aclk;
   end
   // ----------------------------------------------------------------
   // hang guard, far above the ~65 cycles the run needs
   // ----------------------------------------------------------------
   always @(posedge aclk) begin
      cycles++;
      if (cycles == 3000) begin
         miscompares++;
         end_sim();
      end
   end

   task automatic end_sim();
      $display("checked %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic op(input logic [1:0] s, input logic [2:0] c, input logic r, input logic [13:0] a,
                     input logic [8:0] d);
      host_pins_inst.op(s, c, r, a, d);
   endtask

   task automatic rchk(input logic [8:0] d);
      chk(32'(read_data), 32'(d));
      chk(32'(read_data_oe_n), 32'h0);
   endtask
   // ----------------------------------------------------------------
   // axi4-lite master, one transfer at a time
   // ----------------------------------------------------------------
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
      end while (s_axi_bvalid !== 1'h1);
      s_axi_bready <= 1'h0;
      chk(32'(s_axi_bresp), 32'(r));
   endtask

   task automatic axi_rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      @(posedge aclk);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
      end while (s_axi_rvalid !== 1'h1);
      s_axi_rready <= 1'h0;
      chk(s_axi_rdata, d);
      chk(32'(s_axi_rresp), 32'(r));
   endtask
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      {aresetn, output_enable_n, output_latency_select} = 3'h0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
      s_axi_wstrb = 4'hf;
      repeat (4) @(posedge aclk);
      aresetn <= 1'h1;
      @(posedge aclk);
      axi_rd(`REG_CONTROL_OFFSET, 32'h0, `AXI_RESP_OKAY);
      axi_rd(`REG_COUNTER_OFFSET, 32'h0, `AXI_RESP_OKAY);
      axi_rd(8'h10, 32'h0, `AXI_RESP_SLVERR);
      op(SEL, LD, 1'h0, 14'h3ffe, 9'h1a5);
      op(SEL, ADV, 1'h0, 14'h0000, 9'h05a);
      op(OFF, HOLD, 1'h1, 14'h0000, 9'h000);
      axi_rd(`REG_COUNTER_OFFSET, 32'h3fff, `AXI_RESP_OKAY);
      axi_rd(`REG_WRITE_COUNT_OFFSET, 32'h2, `AXI_RESP_OKAY);
      op(SEL, ADV, 1'h0, 14'h0000, 9'h0c3);
      op(SEL, LD, 1'h1, 14'h3ffe, 9'h000);
      rchk(9'h1a5);
      op(SEL, ADV, 1'h1, 14'h0000, 9'h000);
      rchk(9'h05a);
      op(SEL, ADV, 1'h1, 14'h0000, 9'h000);
      rchk(9'h0c3);
      op(SEL, HOLD, 1'h1, 14'h0000, 9'h000);
      rchk(9'h0c3);
      op(SEL, CLR, 1'h0, 14'h0123, 9'h111);
      op(SEL, LD, 1'h1, 14'h0000, 9'h000);
      rchk(9'h111);
      op(OFF, HOLD, 1'h1, 14'h0000, 9'h000);
      op(SEL, LD, 1'h0, 14'h0000, 9'h111);
      axi_wr(`REG_CONTROL_OFFSET, 32'h1, `AXI_RESP_OKAY);
      op(SEL, LD, 1'h0, 14'h0000, 9'h0ff);
      op(SEL, LD, 1'h1, 14'h0000, 9'h000);
      rchk(9'h111);
      axi_rd(`REG_STATUS_OFFSET, 32'ha, `AXI_RESP_OKAY);
      axi_wr(`REG_CONTROL_OFFSET, 32'h0, `AXI_RESP_OKAY);
      axi_wr(`REG_COUNTER_OFFSET, 32'h55, `AXI_RESP_OKAY);
      axi_wr(8'h10, 32'h1, `AXI_RESP_SLVERR);
      axi_rd(`REG_COUNTER_OFFSET, 32'h0, `AXI_RESP_OKAY);
      op(OFF, HOLD, 1'h1, 14'h0000, 9'h000);
      output_latency_select <= 1'h1;
      axi_rd(`REG_STATUS_OFFSET, 32'h5, `AXI_RESP_OKAY);
      op(SEL, LD, 1'h1, 14'h3fff, 9'h000);
      chk(32'(read_data_oe_n), 32'h1);
      op(SEL, HOLD, 1'h1, 14'h0000, 9'h000);
      rchk(9'h05a);
      output_enable_n <= 1'h1;
      #1;
      chk(32'(read_data_oe_n), 32'h1);
      output_enable_n <= 1'h0;
      output_latency_select <= 1'h0;
      #1;
      rchk(9'h05a);
      op(2'h0, HOLD, 1'h1, 14'h0000, 9'h000);
      chk(32'(read_data_oe_n), 32'h1);
      end_sim();
   end
endmodule
